// ---- verilog/lvs_linreg_regs.sv ----
`include "lvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module lvs_linreg_regs
  import lvs_pkg::*;
  #(
    parameter logic [4:0] LINREG1_RESET = `LVS_LINREG1_RESET,
    parameter logic [4:0] LINREG2_RESET = `LVS_LINREG2_RESET,
    parameter int SYNC_TIMEOUT_CYC = `LVS_SYNC_TIMEOUT_CYC
  )
  (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register access from the serial bus decoder
    input wire lvs_reg_req_t reg_req,
    output logic [7:0] reg_rdata_r,
    output logic reg_rvalid_r,
    // sync pin and converter mode
    input wire logic sync_in,
    input wire logic pwm_mode,
    // regulator level codes
    output logic [4:0] linreg1_level_code,
    output logic [4:0] linreg2_level_code,
    output logic [4:0] linreg1_level_eff,
    output logic [4:0] linreg2_level_eff,
    // converter timing
    output logic conv_clk_r,
    output logic conv_ext_sel_r
  );

  localparam logic [7:0] INT_INC = 8'(2 * `LVS_CONV_MHZ);
  localparam logic [7:0] INT_MOD = 8'(`LVS_CLK_MHZ);
  localparam logic [7:0] EXT_INC = 8'(2 * `LVS_CONV_MHZ);
  localparam logic [7:0] EXT_MOD = 8'(`LVS_SYNC_MHZ);
  localparam logic [7:0] TMO = 8'(SYNC_TIMEOUT_CYC);

  ////////////////////////////////////////////////////////////////////////
  // register decode

  logic [4:0] level_r [2];
  logic [4:0] eff_r [2];
  logic [7:0] reg_ofs [2];
  logic [1:0] hit;
  logic [7:0] rd_mux;

  assign reg_ofs[0] = `LVS_LINREG1_LEVEL_SELECT_OFS;
  assign reg_ofs[1] = `LVS_LINREG2_LEVEL_SELECT_OFS;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_level
      logic [4:0] rst_val;
      logic [4:0] lvl_nxt;
      logic [4:0] eff_nxt;
      assign rst_val = (g == 0) ? LINREG1_RESET : LINREG2_RESET;
      assign hit[g] = (reg_req.addr == reg_ofs[g]);
      assign lvl_nxt = (reg_req.wr && hit[g]) ?
                       reg_req.wdata[`LVS_LEVEL_W-1:0] : level_r[g];
      assign eff_nxt = (level_r[g] > `LVS_LEVEL_MAX) ?
                       `LVS_LEVEL_MAX : level_r[g];
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          level_r[g] <= rst_val;
          eff_r[g] <= rst_val;
        end
        else
        begin
          level_r[g] <= lvl_nxt;
          eff_r[g] <= eff_nxt;
        end
      end
    end
  endgenerate

  assign rd_mux = hit[0] ? {`LVS_RSVD_READ, level_r[0]} :
                  hit[1] ? {`LVS_RSVD_READ, level_r[1]} : 8'h00;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
      linreg1_level_code <= LINREG1_RESET;
      linreg2_level_code <= LINREG2_RESET;
    end
    else
    begin
      reg_rdata_r <= reg_req.rd ? rd_mux : 8'h00;
      reg_rvalid_r <= reg_req.rd;
      linreg1_level_code <= level_r[0];
      linreg2_level_code <= level_r[1];
    end
  end

  assign linreg1_level_eff = eff_r[0];
  assign linreg2_level_eff = eff_r[1];

  ////////////////////////////////////////////////////////////////////////
  // sync detection and clock source

  logic sync_d_r;
  logic sync_edge;
  logic [7:0] idle_r;
  logic [7:0] idle_nxt;
  logic sync_lost;
  lvs_src_t src_r;
  lvs_src_t src_nxt;

  assign sync_edge = sync_in && !sync_d_r;
  assign sync_lost = (idle_r >= TMO);
  assign idle_nxt = sync_edge ? 8'h00 :
                    sync_lost ? idle_r : 8'(idle_r + 8'h01);

  always_comb
  begin
    src_nxt = src_r;
    case (src_r)
      LVS_SRC_INTERNAL:
        if (sync_edge && pwm_mode)
          src_nxt = LVS_SRC_EXTERNAL;
      LVS_SRC_EXTERNAL:
        if (sync_lost || !pwm_mode)
          src_nxt = LVS_SRC_INTERNAL;
      default:
        src_nxt = LVS_SRC_INTERNAL;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sync_d_r <= 1'b0;
      idle_r <= TMO;
      src_r <= LVS_SRC_INTERNAL;
    end
    else
    begin
      sync_d_r <= sync_in;
      idle_r <= idle_nxt;
      src_r <= src_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter clocks

  logic int_clk;
  logic ext_clk;
  logic int_wrap;
  logic ext_wrap;

  lvs_frac_div #(.INC(INT_INC), .MOD(INT_MOD)) u_int_div (
    .clock(clock),
    .reset(reset),
    .step(1'b1),
    .wrap(int_wrap),
    .div_out(int_clk)
  );

  lvs_frac_div #(.INC(EXT_INC), .MOD(EXT_MOD)) u_ext_div (
    .clock(clock),
    .reset(reset),
    .step(sync_edge),
    .wrap(ext_wrap),
    .div_out(ext_clk)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      conv_clk_r <= 1'b0;
      conv_ext_sel_r <= 1'b0;
    end
    else
    begin
      conv_clk_r <= (src_r == LVS_SRC_EXTERNAL) ? ext_clk : int_clk;
      conv_ext_sel_r <= (src_r == LVS_SRC_EXTERNAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [2:0] gap_r;
  logic [7:0] int_gap_r;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      gap_r <= 3'h0;
      int_gap_r <= 8'h00;
    end
    else
    begin
      if (sync_edge)
        gap_r <= ext_wrap ? 3'h0 : 3'(gap_r + 3'h1);
      int_gap_r <= int_wrap ? 8'h00 : 8'(int_gap_r + 8'h01);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_L1_WRITE: assert property (
    reg_req.wr && hit[0] |=> level_r[0] == $past(reg_req.wdata[4:0]))
    else $error("regulator one level not written");

  AST_L2_SAT: assert property (
    reg_req.wr && hit[1] ##1 !reg_req.wr |=>
      linreg2_level_eff == (($past(reg_req.wdata[4:0], 2) > 5'h19) ?
                            5'h19 : $past(reg_req.wdata[4:0], 2)))
    else $error("regulator two level not saturated");

  AST_RSVD_ZERO: assert property (
    reg_rvalid_r |-> reg_rdata_r[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  AST_RD_VALUE: assert property (
    reg_req.rd && hit[0] && !reg_req.wr |=>
      reg_rvalid_r && reg_rdata_r == {3'h0, $past(level_r[0])})
    else $error("regulator one read value wrong");

  AST_EXT_LOCK: assert property (
    sync_edge && pwm_mode && src_r == LVS_SRC_INTERNAL |=> ##1 conv_ext_sel_r)
    else $error("sync edge in pwm did not select external");

  AST_EXT_RATE: assert property (
    sync_edge && ext_wrap |-> gap_r >= 3'h2 && gap_r <= 3'h3)
    else $error("sync divider ratio wrong");

  AST_INT_RATE: assert property (
    int_wrap |-> int_gap_r == 8'h3d || int_gap_r == 8'h3e)
    else $error("internal divider ratio wrong");

  AST_FALLBACK: assert property (
    sync_lost && !sync_edge |=> ##1 !conv_ext_sel_r)
    else $error("silent sync did not fall back");

  CVR_EXT: cover property (src_r == LVS_SRC_EXTERNAL ##1 ext_wrap);
  CVR_SAT: cover property (reg_req.wr && reg_req.wdata[4:0] > 5'h19);
  CVR_BACK: cover property (src_r == LVS_SRC_EXTERNAL ##1
                            src_r == LVS_SRC_INTERNAL);

endmodule

`default_nettype wire

// ---- pkg/lvs_defines.svh ----
// How it works
// - 0x39 holds regulator one's 5-bit code, 1.0 V + 0.1 V/step, max 0x19.
// - 0x3a holds the same read/write code for regulator two, factory reset.
// - With a clock on the sync input both converters follow it in pwm mode.
// - The 13 MHz sync clock is divided down to a 2 MHz converter rate.
// - A grounded sync input leaves timing on the internal 2 MHz oscillator.
`ifndef LVS_DEFINES_SVH
`define LVS_DEFINES_SVH

// register offsets
`define LVS_LINREG1_LEVEL_SELECT_OFS 8'h39
`define LVS_LINREG2_LEVEL_SELECT_OFS 8'h3a

// level field
`define LVS_LEVEL_LSB 0
`define LVS_LEVEL_W 5
`define LVS_LEVEL_MAX 5'h19
`define LVS_RSVD_READ 3'h0

// factory default codes (plain defaults, overridable)
`define LVS_LINREG1_RESET 5'h08
`define LVS_LINREG2_RESET 5'h17

// clock rates in MHz
`define LVS_CLK_MHZ 250
`define LVS_SYNC_MHZ 13
`define LVS_CONV_MHZ 2

// sync silence before falling back to internal timing
`define LVS_SYNC_TIMEOUT_NS 200
`define LVS_SYNC_TIMEOUT_CYC \
  ((`LVS_SYNC_TIMEOUT_NS * `LVS_CLK_MHZ + 999) / 1000)

`endif

// ---- pkg/lvs_pkg.sv ----
package lvs_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lvs_reg_req_t;

  typedef enum logic [1:0] {
    LVS_SRC_INTERNAL = 2'b01,
    LVS_SRC_EXTERNAL = 2'b10
  } lvs_src_t;

endpackage

// ---- verilog/lvs_frac_div.sv ----
`timescale 1ns/1ps
`default_nettype none

// fractional divider: toggles its output at INC/MOD of the step rate
module lvs_frac_div
  #(
    parameter logic [7:0] INC = 8'h04,
    parameter logic [7:0] MOD = 8'hfa
  )
  (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // step in
    input wire logic step,
    // divided out
    output logic wrap,
    output logic div_out
  );

  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [8:0] sum;

  assign sum = {1'b0, acc_r} + {1'b0, INC};
  assign wrap = step && (sum >= {1'b0, MOD});
  assign acc_nxt = !step ? acc_r :
                   wrap ? 8'(sum - {1'b0, MOD}) : sum[7:0];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      acc_r <= 8'h00;
      div_out <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      div_out <= div_out ^ wrap;
    end
  end

endmodule

`default_nettype wire

// ---- tb/lvs_sync_src.sv ----
`timescale 1ns/1ps
`default_nettype none

// system clock source for the sync pin, grounded while not running
module lvs_sync_src (
  // control
  input wire logic run,
  // sync pin
  output logic sync_in
);
  always
  begin
    sync_in = 1'b0;
    wait (run);
    while (run)
    begin
      #38.462 sync_in = ~sync_in;
    end
  end
endmodule

`default_nettype wire

// ---- tb/linreg_voltage_regs_and_sync_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module linreg_voltage_regs_and_sync_tb;
  import lvs_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  lvs_reg_req_t req = '0;
  logic pwm_mode = 1'b0;
  logic run = 1'b0;
  logic sync_in;
  logic [7:0] rdata;
  logic rvalid;
  logic [4:0] c1, c2, e1, e2;
  logic cclk, esel;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h672f;

  always #2 clock = ~clock;

  lvs_linreg_regs #(.SYNC_TIMEOUT_CYC(50)) dut_u (
    .clock(clock), .reset(reset), .reg_req(req),
    .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
    .sync_in(sync_in), .pwm_mode(pwm_mode),
    .linreg1_level_code(c1), .linreg2_level_code(c2),
    .linreg1_level_eff(e1), .linreg2_level_eff(e2),
    .conv_clk_r(cclk), .conv_ext_sel_r(esel)
  );

  lvs_sync_src src_u (.run(run), .sync_in(sync_in));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [7:0] clamp(input logic [4:0] c);
    return (c > 5'h19) ? 8'h19 : {3'h0, c};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock) #1;
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock) #1;
    chk("rvalid", 8'h01, {7'h0, rvalid});
    q = rdata;
    req = '0;
  endtask

  // toggles of the converter clock over 8 us: 32 at 2 MHz
  task automatic conv_rate(input string nm);
    int n;
    logic p;
    n = 0;
    p = cclk;
    repeat (2000)
    begin
      @(posedge clock) #1;
      if (cclk !== p)
        n++;
      p = cclk;
    end
    chk(nm, 8'h20, (n >= 31 && n <= 33) ? 8'h20 : n[7:0]);
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] q, a, d, x;
    logic [4:0] m [2];
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    m[0] = 5'h08;
    m[1] = 5'h17;
    for (int k = 0; k < 2; k++)
    begin
      rd(8'h39 + k[7:0], q);
      chk("reset value", {3'h0, m[k]}, q);
    end
    $display("test reset done");
    for (int i = 0; i < 48; i++)
    begin
      seed = xs(seed);
      a = (i < 8) ? 8'h39 + {7'h0, i[0]} : 8'h38 + {6'h0, seed[1:0]};
      d = (i < 8) ? 8'he0 + {3'h0, i[1] ? 5'h1a : 5'h19} : seed[15:8];
      if (i == 6 || i == 7)
        d = {i[0] ? 3'h7 : 3'h0, 5'h00};
      wr(a, d);
      if (a == 8'h39 || a == 8'h3a)
        m[a[1]] = d[4:0];
      repeat (2) @(posedge clock);
      #1;
      chk("code1", {3'h0, m[0]}, {3'h0, c1});
      chk("code2", {3'h0, m[1]}, {3'h0, c2});
      chk("eff1", clamp(m[0]), {3'h0, e1});
      chk("eff2", clamp(m[1]), {3'h0, e2});
      rd(a, q);
      x = (a == 8'h39 || a == 8'h3a) ? {3'h0, m[a[1]]} : 8'h00;
      chk("readback", x, q);
    end
    $display("test registers done");
    conv_rate("internal rate");
    chk("ext_sel idle", 8'h00, {7'h0, esel});
    pwm_mode = 1'b1;
    run = 1'b1;
    repeat (40) @(posedge clock);
    #1;
    chk("ext_sel sync", 8'h01, {7'h0, esel});
    conv_rate("external rate");
    @(posedge clock) #1 pwm_mode = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("ext_sel pfm", 8'h00, {7'h0, esel});
    // sync edges keep coming while pwm is low
    repeat (24) @(posedge clock);
    #1;
    chk("ext_sel pfm hold", 8'h00, {7'h0, esel});
    pwm_mode = 1'b1;
    repeat (40) @(posedge clock);
    #1;
    chk("ext_sel back", 8'h01, {7'h0, esel});
    run = 1'b0;
    repeat (80) @(posedge clock);
    #1;
    chk("ext_sel ground", 8'h00, {7'h0, esel});
    conv_rate("fallback rate");
    $display("test sync done");
    end_sim();
  end
endmodule

`default_nettype wire
